// ==== ppl_params.svh ====
/*
 * constants of the periodic poll list control block: command codes,
 * field positions, reset values.
 * assumes nothing; definitions only.
 */
`ifndef PPL_PARAMS_SVH
`define PPL_PARAMS_SVH

`define PPL_CMD_PORT_RD 8'h43
`define PPL_CMD_PORT_WR 8'hc3
`define PPL_CMD_BLK_RD 8'h53
`define PPL_CMD_BLK_WR 8'hd3
`define PPL_CMD_DONE_RD 8'h17
`define PPL_CMD_SKIP_RD 8'h18
`define PPL_CMD_SKIP_WR 8'h98
`define PPL_CMD_LAST_RD 8'h19
`define PPL_CMD_LAST_WR 8'h99
`define PPL_CMD_ACTIVE_RD 8'h1a
`define PPL_BLK_MSB 9
`define PPL_BLK_RESET 10'h040
`define PPL_BLK_MAX 11'h400
`define PPL_MAP_RESET 32'h0000_0000
`define PPL_ACTIVE_RESET 5'h00
`define PPL_ACTIVE_MSB 4

`endif

// ==== ppl_pkg.sv ====
/*
 * types of the periodic poll list control block.
 * assumes ppl_params.svh is not needed here.
 */
package ppl_pkg;

    // one processor bus cycle: command phase or data phase
    typedef struct packed {
        logic cmd;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } ppl_bus_t;

    // completion report from the transfer engine for one descriptor
    typedef struct packed {
        logic valid;
        logic acked;
        logic [4:0] index;
    } ppl_done_t;

    typedef enum logic [1:0] {
        PPL_IDLE,
        PPL_WALK,
        PPL_ATL
    } ppl_walk_t;

endpackage : ppl_pkg

// ==== ppl_walker.sv ====
/*
 * walker over the periodic descriptor list: steps the active index,
 * passes skipped slots, hands over to the aperiodic list after the last.
 * assumes frame_start_i and the done report are on clk_i.
 */
`timescale 1ns/1ns
`include "ppl_params.svh"

module ppl_walker
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // maps and frame
    input wire logic frame_start_i,
    input wire logic [31:0] skip_map_i,
    input wire logic [31:0] last_map_i,
    input wire ppl_pkg::ppl_done_t done_i,
    // walk status
    output logic [4:0] active_index_o,
    output logic process_o,
    output logic aperiodic_go_o
);

    ppl_pkg::ppl_walk_t state_q;
    logic [4:0] index_q;

    assign active_index_o = index_q;
    // skipped descriptors are never offered for processing
    assign process_o = (state_q == ppl_pkg::PPL_WALK) && !skip_map_i[index_q];
    assign aperiodic_go_o = (state_q == ppl_pkg::PPL_ATL);

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= ppl_pkg::PPL_IDLE;
            index_q <= `PPL_ACTIVE_RESET;
        end
        else
        begin
            case (state_q)
                ppl_pkg::PPL_IDLE:
                begin
                    if (frame_start_i)
                    begin
                        state_q <= ppl_pkg::PPL_WALK;
                        index_q <= `PPL_ACTIVE_RESET;
                    end
                end
                ppl_pkg::PPL_WALK:
                begin
                    if (skip_map_i[index_q] || (done_i.valid && done_i.index == index_q))
                    begin
                        if (last_map_i[index_q] || index_q == 5'h1f)
                            state_q <= ppl_pkg::PPL_ATL;
                        else
                            index_q <= index_q + 5'h01;
                    end
                end
                ppl_pkg::PPL_ATL:
                begin
                    if (frame_start_i)
                    begin
                        state_q <= ppl_pkg::PPL_WALK;
                        index_q <= `PPL_ACTIVE_RESET;
                    end
                end
                default:
                    state_q <= ppl_pkg::PPL_IDLE;
            endcase
        end
    end

    property p_skip_not_processed;
        @(posedge clk_i) disable iff (!reset_n_i)
        (state_q == ppl_pkg::PPL_WALK && skip_map_i[index_q])
        |=> (active_index_o != $past(active_index_o)) || aperiodic_go_o;
    endproperty
    a_skip_not_processed: assert property (p_skip_not_processed)
        else $error("skipped descriptor held as active");

    property p_last_hands_over;
        @(posedge clk_i) disable iff (!reset_n_i)
        (state_q == ppl_pkg::PPL_WALK && last_map_i[index_q] && !skip_map_i[index_q]
         && done_i.valid && done_i.index == index_q && !frame_start_i)
        |=> aperiodic_go_o;
    endproperty
    a_last_hands_over: assert property (p_last_hands_over)
        else $error("walk did not stop after last descriptor");

    property p_index_steps;
        @(posedge clk_i) disable iff (!reset_n_i)
        (state_q == ppl_pkg::PPL_WALK && skip_map_i[index_q] && !last_map_i[index_q]
         && index_q != 5'h1f)
        |=> active_index_o == $past(active_index_o) + 5'h01;
    endproperty
    a_index_steps: assert property (p_index_steps)
        else $error("active index did not advance past skipped slot");

    c_handover: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(aperiodic_go_o));

endmodule : ppl_walker

// ==== ppl_ctrl.sv ====
/*
 * periodic poll list control: command-coded processor port with an
 * auto-incrementing list buffer, block size, done/skip/last maps and the
 * active descriptor index.
 * assumes the processor port and engine signals are already on clk_i.
 */
`timescale 1ns/1ns
`include "ppl_params.svh"

// What this block does
// - 43h reads list buffer, c3h writes it
// - buffer pointer advances after every 43h/c3h data access
// - count reached sets end flag, fill status
// - block size resets 64, never above 1024
// - block size bits 9:0, codes 53/d3
// - 32-bit done map read with code 17
// - done map updated per frame, read clears
// - done bit set only on acked descriptor
// - skipped descriptors not processed, map 18/98
// - skip map resets to zero
// - after last descriptor go aperiodic list
// - active index 5 bits, resets zero, 1a
// - list port access always starts address zero
module ppl_ctrl #(
    parameter int BUF_WORDS = 2048
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // processor port
    input wire ppl_pkg::ppl_bus_t bus_i,
    output logic [15:0] rdata_o,
    // byte counter from the transfer counter logic; end flag and fill status are made here
    input wire logic [15:0] transfer_byte_counter_i,
    output logic all_transfers_end_flag_o,
    output logic buffer_fill_status_o,
    // engine side
    input wire logic frame_start_i,
    input wire ppl_pkg::ppl_done_t done_i,
    output logic [4:0] active_index_o,
    output logic process_o,
    output logic aperiodic_go_o,
    output logic [9:0] block_size_o
);

    localparam int AW = $clog2(BUF_WORDS);

    logic [7:0] cmd_q;
    logic [15:0] byte_ptr_q;
    logic [15:0] buf_mem [BUF_WORDS];
    logic [9:0] blk_q;
    logic [31:0] done_q;
    logic [31:0] done_frame_q;
    logic [31:0] skip_q;
    logic [31:0] last_q;
    logic half_q;
    logic eot_q;
    logic fill_q;
    logic data_rd;
    logic data_wr;
    logic done_clear;
    logic [15:0] next_ptr;
    logic [4:0] active_index;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    assign data_rd = bus_i.rd && !bus_i.cmd;
    assign data_wr = bus_i.wr && !bus_i.cmd;
    assign next_ptr = byte_ptr_q + 16'h0002;

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            cmd_q <= 8'h00;
        else if (bus_i.cmd && bus_i.wr)
            cmd_q <= bus_i.wdata[7:0];
    end

    // ----------------------------------------
    // list buffer port
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            byte_ptr_q <= 16'h0000;
        else if (bus_i.cmd && bus_i.wr)
            byte_ptr_q <= 16'h0000;
        else if ((data_rd && cmd_q == `PPL_CMD_PORT_RD)
                 || (data_wr && cmd_q == `PPL_CMD_PORT_WR))
            byte_ptr_q <= next_ptr;
    end

    always_ff @(posedge clk_i)
    begin
        if (data_wr && cmd_q == `PPL_CMD_PORT_WR)
            buf_mem[byte_ptr_q[AW:1]] <= bus_i.wdata;
    end

    // end flag raised once the pointer meets the loaded count
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            eot_q <= 1'b0;
            fill_q <= 1'b0;
        end
        else if (bus_i.cmd && bus_i.wr)
            eot_q <= 1'b0;
        else if (((data_rd && cmd_q == `PPL_CMD_PORT_RD)
                  || (data_wr && cmd_q == `PPL_CMD_PORT_WR))
                 && next_ptr >= transfer_byte_counter_i)
        begin
            eot_q <= 1'b1;
            fill_q <= (cmd_q == `PPL_CMD_PORT_WR);
        end
    end

    assign all_transfers_end_flag_o = eot_q;
    assign buffer_fill_status_o = fill_q;

    // ----------------------------------------
    // block size
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            blk_q <= `PPL_BLK_RESET;
        // the whole written word is judged, so values above 1024 are dropped; 1024 itself is taken and stored as zero in bits 9:0
        else if (data_wr && cmd_q == `PPL_CMD_BLK_WR
                 && bus_i.wdata <= {5'h00, `PPL_BLK_MAX})
            blk_q <= bus_i.wdata[`PPL_BLK_MSB:0];
    end

    assign block_size_o = blk_q;

    // ----------------------------------------
    // skip and last maps, written low half then high half
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            half_q <= 1'b0;
        else if (bus_i.cmd && bus_i.wr)
            half_q <= 1'b0;
        else if (data_rd || data_wr)
            half_q <= !half_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            skip_q <= `PPL_MAP_RESET;
        else if (data_wr && cmd_q == `PPL_CMD_SKIP_WR)
        begin
            if (half_q)
                skip_q[31:16] <= bus_i.wdata;
            else
                skip_q[15:0] <= bus_i.wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            last_q <= `PPL_MAP_RESET;
        else if (data_wr && cmd_q == `PPL_CMD_LAST_WR)
        begin
            if (half_q)
                last_q[31:16] <= bus_i.wdata;
            else
                last_q[15:0] <= bus_i.wdata;
        end
    end

    // ----------------------------------------
    // done map: collected during the frame, published at frame start
    // ----------------------------------------
    assign done_clear = data_rd && cmd_q == `PPL_CMD_DONE_RD && half_q;

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            done_frame_q <= `PPL_MAP_RESET;
        else if (frame_start_i)
            done_frame_q <= `PPL_MAP_RESET;
        else if (done_i.valid && done_i.acked)
            done_frame_q[done_i.index] <= 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            done_q <= `PPL_MAP_RESET;
        else if (frame_start_i)
            done_q <= (done_clear ? 32'h0000_0000 : done_q) | done_frame_q;
        else if (done_clear)
            done_q <= 32'h0000_0000;
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            rdata_o <= 16'h0000;
        else if (data_rd)
        begin
            case (cmd_q)
                `PPL_CMD_PORT_RD: rdata_o <= buf_mem[byte_ptr_q[AW:1]];
                `PPL_CMD_BLK_RD: rdata_o <= {6'h00, blk_q};
                `PPL_CMD_DONE_RD: rdata_o <= half_q ? done_q[31:16] : done_q[15:0];
                `PPL_CMD_SKIP_RD: rdata_o <= half_q ? skip_q[31:16] : skip_q[15:0];
                `PPL_CMD_LAST_RD: rdata_o <= half_q ? last_q[31:16] : last_q[15:0];
                `PPL_CMD_ACTIVE_RD: rdata_o <= {11'h000, active_index};
                default: rdata_o <= 16'h0000;
            endcase
        end
    end

    ppl_walker u_walker (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .frame_start_i(frame_start_i),
        .skip_map_i(skip_q),
        .last_map_i(last_q),
        .done_i(done_i),
        .active_index_o(active_index),
        .process_o(process_o),
        .aperiodic_go_o(aperiodic_go_o)
    );

    assign active_index_o = active_index;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_ptr_advance;
        @(posedge clk_i) disable iff (!reset_n_i)
        (data_rd && cmd_q == `PPL_CMD_PORT_RD && !bus_i.wr)
        |=> byte_ptr_q == $past(byte_ptr_q) + 16'h0002;
    endproperty
    a_ptr_advance: assert property (p_ptr_advance)
        else $error("list pointer did not advance");

    property p_ptr_zero;
        @(posedge clk_i) disable iff (!reset_n_i)
        (bus_i.cmd && bus_i.wr) |=> byte_ptr_q == 16'h0000;
    endproperty
    a_ptr_zero: assert property (p_ptr_zero)
        else $error("list pointer not at zero after command");

    property p_eot;
        @(posedge clk_i) disable iff (!reset_n_i)
        (data_wr && cmd_q == `PPL_CMD_PORT_WR && next_ptr >= transfer_byte_counter_i)
        |=> all_transfers_end_flag_o && buffer_fill_status_o;
    endproperty
    a_eot: assert property (p_eot)
        else $error("end flag not raised at byte count");

    property p_blk_limit;
        @(posedge clk_i) disable iff (!reset_n_i)
        (data_wr && cmd_q == `PPL_CMD_BLK_WR && bus_i.wdata > {5'h00, `PPL_BLK_MAX})
        |=> $stable(block_size_o);
    endproperty
    a_blk_limit: assert property (p_blk_limit)
        else $error("oversized block size accepted");

    property p_done_clear;
        @(posedge clk_i) disable iff (!reset_n_i)
        (done_clear && !frame_start_i) |=> done_q == 32'h0000_0000;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done map not cleared by read");

    property p_done_keep;
        @(posedge clk_i) disable iff (!reset_n_i)
        (frame_start_i && done_frame_q != 32'h0) |=> (done_q & $past(done_frame_q)) != 32'h0;
    endproperty
    a_done_keep: assert property (p_done_keep)
        else $error("new done bit lost on read clear");

    property p_done_needs_ack;
        @(posedge clk_i) disable iff (!reset_n_i)
        (done_i.valid && !done_i.acked && !frame_start_i && !done_frame_q[done_i.index])
        |=> !done_frame_q[$past(done_i.index)];
    endproperty
    a_done_needs_ack: assert property (p_done_needs_ack)
        else $error("done bit set without ack");

    property p_skip_write;
        @(posedge clk_i) disable iff (!reset_n_i)
        (data_wr && cmd_q == `PPL_CMD_SKIP_WR && !half_q)
        |=> skip_q[15:0] == $past(bus_i.wdata);
    endproperty
    a_skip_write: assert property (p_skip_write)
        else $error("skip map low half not written");

    c_port_write: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        data_wr && cmd_q == `PPL_CMD_PORT_WR);
    c_eot: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(all_transfers_end_flag_o));
    c_done_race: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        done_clear && frame_start_i);

endmodule : ppl_ctrl

// ==== ppl_host_model.sv ====
/*
 * host processor model: command, data write and data read cycles on the
 * list control port, plus the loaded transfer byte count.
 * assumes the port samples bus_o at the rising edge of clk_i.
 */
`timescale 1ns/1ns

module ppl_host_model
(
    // clock
    input wire logic clk_i,
    // processor port
    output ppl_pkg::ppl_bus_t bus_o,
    input wire logic [15:0] rdata_i,
    output logic [15:0] transfer_byte_counter_o
);
    initial
    begin
        bus_o = '0;
        transfer_byte_counter_o = 16'h0000;
    end

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    task automatic set_count(input logic [15:0] n);
        @(posedge clk_i);
        transfer_byte_counter_o <= n;
    endtask : set_count

    task automatic send_cmd(input logic [7:0] code);
        @(posedge clk_i);
        bus_o <= '{1'b1, 1'b1, 1'b0, {8'h00, code}};
        @(posedge clk_i);
        bus_o <= '0;
    endtask : send_cmd

    task automatic wr_word(input logic [15:0] d);
        @(posedge clk_i);
        bus_o <= '{1'b0, 1'b1, 1'b0, d};
        @(posedge clk_i);
        bus_o <= '0;
    endtask : wr_word

    task automatic rd_word(output logic [15:0] d);
        @(posedge clk_i);
        bus_o <= '{1'b0, 1'b0, 1'b1, 16'h0000};
        @(posedge clk_i);
        bus_o <= '0;
        #1;
        d = rdata_i;
    endtask : rd_word

    // 32-bit maps go low half first, then high half
    task automatic wr_map(input logic [7:0] code, input logic [31:0] d);
        send_cmd(code);
        wr_word(d[15:0]);
        wr_word(d[31:16]);
    endtask : wr_map

    task automatic rd_map(input logic [7:0] code, output logic [31:0] d);
        logic [15:0] lo;
        logic [15:0] hi;
        send_cmd(code);
        rd_word(lo);
        rd_word(hi);
        d = {hi, lo};
    endtask : rd_map
endmodule : ppl_host_model

// ==== testbench.sv ====
/*
 * testbench of ppl_ctrl: register codes, list buffer port, walker maps.
 * assumes ppl_host_model drives the processor port.
 */
`timescale 1ns/1ns
`include "ppl_params.svh"

module testbench;
    logic clk_i;
    logic reset_n_i;
    logic frame_start_i;
    ppl_pkg::ppl_bus_t bus_i;
    ppl_pkg::ppl_done_t done_i;
    logic [15:0] rdata_o;
    logic [15:0] cnt;
    logic all_transfers_end_flag_o;
    logic buffer_fill_status_o;
    logic process_o;
    logic aperiodic_go_o;
    logic [4:0] active_index_o;
    logic [9:0] block_size_o;
    logic [31:0] v;
    logic [15:0] w;
    int err_total;
    int n_compared;

    ppl_host_model host (.clk_i(clk_i), .bus_o(bus_i), .rdata_i(rdata_o),
        .transfer_byte_counter_o(cnt));

    ppl_ctrl #(.BUF_WORDS(2048)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .transfer_byte_counter_i(cnt),
        .all_transfers_end_flag_o(all_transfers_end_flag_o),
        .buffer_fill_status_o(buffer_fill_status_o), .frame_start_i(frame_start_i),
        .done_i(done_i), .active_index_o(active_index_o), .process_o(process_o),
        .aperiodic_go_o(aperiodic_go_o), .block_size_o(block_size_o));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd_reg(input logic [7:0] code, output logic [15:0] d);
        host.send_cmd(code);
        host.rd_word(d);
    endtask : rd_reg

    task automatic wr_reg(input logic [7:0] code, input logic [15:0] d);
        host.send_cmd(code);
        host.wr_word(d);
    endtask : wr_reg

    task automatic frame();
        @(posedge clk_i);
        frame_start_i <= 1'b1;
        @(posedge clk_i);
        frame_start_i <= 1'b0;
    endtask : frame

    task automatic eng_done(input logic [4:0] idx, input logic ack);
        @(posedge clk_i);
        done_i <= '{1'b1, ack, idx};
        @(posedge clk_i);
        done_i <= '0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : eng_done

    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask : settle

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        summarize();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        err_total = 0;
        n_compared = 0;
        reset_n_i = 1'b0;
        frame_start_i = 1'b0;
        done_i = '0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd_reg(`PPL_CMD_BLK_RD, w);
        chk(w, 32'h0040);
        chk(block_size_o, 32'h040);
        host.rd_map(`PPL_CMD_SKIP_RD, v);
        chk(v, 32'h0);
        host.rd_map(`PPL_CMD_LAST_RD, v);
        chk(v, 32'h0);
        host.rd_map(`PPL_CMD_DONE_RD, v);
        chk(v, 32'h0);
        rd_reg(`PPL_CMD_ACTIVE_RD, w);
        chk(w, 32'h0);
        $display("test reset done");

        wr_reg(`PPL_CMD_BLK_WR, 16'h0408);
        rd_reg(`PPL_CMD_BLK_RD, w);
        chk(w, 32'h0040);
        wr_reg(`PPL_CMD_BLK_WR, 16'h03f8);
        rd_reg(`PPL_CMD_BLK_RD, w);
        chk(w, 32'h03f8);
        wr_reg(`PPL_CMD_BLK_WR, 16'h0018);
        rd_reg(`PPL_CMD_BLK_RD, w);
        chk(w, 32'h0018);
        chk(block_size_o, 32'h018);
        $display("test block size done");

        host.set_count(16'h0004);
        host.send_cmd(`PPL_CMD_PORT_WR);
        host.wr_word(16'ha5a5);
        settle();
        chk(all_transfers_end_flag_o, 32'h0);
        host.wr_word(16'h5a5a);
        settle();
        chk(all_transfers_end_flag_o, 32'h1);
        chk(buffer_fill_status_o, 32'h1);
        host.send_cmd(`PPL_CMD_PORT_RD);
        settle();
        chk(all_transfers_end_flag_o, 32'h0);
        host.rd_word(w);
        chk(w, 32'ha5a5);
        host.rd_word(w);
        chk(w, 32'h5a5a);
        settle();
        chk(all_transfers_end_flag_o, 32'h1);
        chk(buffer_fill_status_o, 32'h0);
        $display("test buffer port done");

        host.wr_map(`PPL_CMD_SKIP_WR, 32'h0000_0002);
        host.wr_map(`PPL_CMD_LAST_WR, 32'h0000_0008);
        host.rd_map(`PPL_CMD_SKIP_RD, v);
        chk(v, 32'h0000_0002);
        host.rd_map(`PPL_CMD_LAST_RD, v);
        chk(v, 32'h0000_0008);
        rd_reg(`PPL_CMD_ACTIVE_RD, w);
        chk(w, 32'h0);
        frame();
        settle();
        chk(process_o, 32'h1);
        eng_done(5'h00, 1'b1);
        chk(active_index_o, 32'h02);
        chk(process_o, 32'h1);
        eng_done(5'h02, 1'b0);
        chk(active_index_o, 32'h03);
        eng_done(5'h03, 1'b1);
        chk(aperiodic_go_o, 32'h1);
        chk(process_o, 32'h0);
        host.rd_map(`PPL_CMD_DONE_RD, v);
        chk(v, 32'h0);
        frame();
        host.rd_map(`PPL_CMD_DONE_RD, v);
        chk(v, 32'h0000_0009);
        host.rd_map(`PPL_CMD_DONE_RD, v);
        chk(v, 32'h0);
        $display("test walk done");

        // frame start publishing a new completion lands in the same cycle as the clearing read
        eng_done(5'h00, 1'b1);
        host.send_cmd(`PPL_CMD_DONE_RD);
        host.rd_word(w);
        fork
            host.rd_word(w);
            frame();
        join
        host.rd_map(`PPL_CMD_DONE_RD, v);
        chk(v, 32'h0000_0001);
        $display("test clear race done");
        summarize();
    end
endmodule : testbench
